// file: logic/aocc_pkg.sv
package aocc_pkg;
	// ==========================================
	// switch field positions (bit 0 is pin 1)
	localparam int SW_W = 10;
	localparam int SW_RNG_A_LSB = 0;
	localparam int SW_RNG_B_LSB = 3;
	localparam int SW_RSVD = 6;
	localparam int SW_POL_A = 7;
	localparam int SW_POL_B = 8;
	localparam int SW_NET_EN = 9;

	// ==========================================
	// data path widths
	localparam int WORD_W = 16;
	localparam int BUF_W = WORD_W + 1;
	localparam int N_CH = 4;
	localparam int DAC_W = 13;
	localparam int TICK_W = 17;
	localparam int SETTLE_W = 3;

	// ==========================================
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int REFRESH_MS = 4;
	localparam int REFRESH_CYCLES = (CLK_HZ / 1000) * REFRESH_MS;
	localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = 3'h4;

	// ==========================================
	// input word bounds of the extended span, signed
	localparam logic signed [WORD_W:0] UNI_LO = -17'sh0012c;
	localparam logic signed [WORD_W:0] UNI_HI = 17'sh0189c;
	localparam logic signed [WORD_W:0] BIP_LO = -17'sh00ce4;
	localparam logic signed [WORD_W:0] BIP_HI = 17'sh00ce4;

	// converter codes: 0 is bottom of extended span
	localparam logic [DAC_W-1:0] CODE_MIN = 13'h0000;
	localparam logic [DAC_W-1:0] CODE_MAX = 13'h19c8;
	localparam logic [DAC_W-1:0] CODE_MID = 13'h0ce4;

	// ==========================================
	// modes
	typedef enum logic [1:0] {
		AOCC_RNG_0_5,
		AOCC_RNG_1_5,
		AOCC_RNG_0_10,
		AOCC_RNG_PM10
	} aocc_range_t;

	typedef enum logic [1:0] {
		AOCC_POL_CLR_MIN,
		AOCC_POL_CLR_MAX,
		AOCC_POL_CLR_ZERO,
		AOCC_POL_HOLD
	} aocc_policy_t;

	typedef enum logic {
		AOCC_ST_SETTLE,
		AOCC_ST_RUN
	} aocc_state_t;

	localparam aocc_range_t RNG_RESET = AOCC_RNG_0_5;
	localparam aocc_policy_t POL_RESET = AOCC_POL_CLR_MIN;
endpackage : aocc_pkg

// file: logic/aocc_word_if.sv
interface aocc_word_if;
	logic valid;
	logic ready;
	logic [aocc_pkg::BUF_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : aocc_word_if

// file: logic/aocc_word_buf.sv
module aocc_word_buf (
	input wire logic core_clk,
	input wire logic rst_n,
	aocc_word_if.snk wr,
	aocc_word_if.src rd
);
	typedef struct packed {
		logic [1:0][aocc_pkg::BUF_W-1:0] mem;
		logic wptr;
		logic rptr;
		logic [1:0] cnt;
	} aocc_buf_t;

	aocc_buf_t st_q;
	aocc_buf_t st_d;
	logic push;
	logic pop;

	assign wr.ready = (st_q.cnt != 2'h2);
	assign rd.valid = (st_q.cnt != 2'h0);
	assign rd.data = st_q.mem[st_q.rptr];

	always_comb begin
		st_d = st_q;
		push = wr.valid && wr.ready;
		pop = rd.valid && rd.ready;
		if (push) begin
			st_d.mem[st_q.wptr] = wr.data;
			st_d.wptr = ~st_q.wptr;
		end
		if (pop) begin
			st_d.rptr = ~st_q.rptr;
		end
		st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule : aocc_word_buf

// file: logic/aocc_top.sv
module aocc_top #(
	parameter int REFRESH_CYCLES = aocc_pkg::REFRESH_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [aocc_pkg::SW_W-1:0] dip_sw,
	input wire logic net_cfg_wr,
	input wire logic [7:0] net_range,
	input wire logic [1:0] net_policy,
	input wire logic bus_comm_err,
	input wire logic link_comm_err,
	input wire logic in_valid,
	input wire logic in_first,
	input wire logic [aocc_pkg::WORD_W-1:0] in_word,
	output logic in_ready,
	output logic [aocc_pkg::N_CH-1:0][aocc_pkg::DAC_W-1:0] dac_code,
	output logic dac_update,
	output logic [7:0] range_sel,
	output logic [1:0] policy_sel,
	output logic [1:0] cfg_fault,
	output logic net_mode
);
	// ==========================================
	// state
	typedef struct packed {
		logic [aocc_pkg::SW_W-1:0] s1;
		logic [aocc_pkg::SW_W-1:0] s2;
		logic [aocc_pkg::SW_W-1:0] s3;
		logic [aocc_pkg::SW_W-1:0] sw;
		logic [aocc_pkg::SETTLE_W-1:0] settle;
		aocc_pkg::aocc_state_t fsm;
		aocc_pkg::aocc_range_t [aocc_pkg::N_CH-1:0] rng;
		aocc_pkg::aocc_policy_t pol;
		logic net;
		logic [1:0] fault;
		logic [1:0] widx;
		logic [aocc_pkg::N_CH-1:0][aocc_pkg::WORD_W-1:0] stage;
		logic set_full;
		logic [aocc_pkg::TICK_W-1:0] tick;
		logic [aocc_pkg::N_CH-1:0][aocc_pkg::DAC_W-1:0] dac;
		logic upd;
	} aocc_state_t;

	aocc_state_t st_q;
	aocc_state_t st_d;

	localparam logic [aocc_pkg::TICK_W-1:0] TICK_LAST = aocc_pkg::TICK_W'(REFRESH_CYCLES - 1);

	// ==========================================
	// decode helpers
	function automatic logic [2:0] dec_range(input logic [2:0] f);
		// {valid, range}
		unique case (f)
			3'h0: dec_range = {1'b1, aocc_pkg::AOCC_RNG_0_5};
			3'h1: dec_range = {1'b1, aocc_pkg::AOCC_RNG_1_5};
			3'h2: dec_range = {1'b1, aocc_pkg::AOCC_RNG_0_10};
			3'h3: dec_range = {1'b1, aocc_pkg::AOCC_RNG_PM10};
			default: dec_range = {1'b0, aocc_pkg::AOCC_RNG_0_5};
		endcase
	endfunction : dec_range

	function automatic aocc_pkg::aocc_policy_t dec_policy(input logic p8, input logic p9);
		unique case ({p8, p9})
			2'h0: dec_policy = aocc_pkg::AOCC_POL_CLR_MIN;
			2'h1: dec_policy = aocc_pkg::AOCC_POL_CLR_MAX;
			2'h2: dec_policy = aocc_pkg::AOCC_POL_CLR_ZERO;
			2'h3: dec_policy = aocc_pkg::AOCC_POL_HOLD;
		endcase
	endfunction : dec_policy

	function automatic logic [aocc_pkg::DAC_W-1:0] conv(input logic [aocc_pkg::WORD_W-1:0] w,
			input aocc_pkg::aocc_range_t r);
		logic signed [aocc_pkg::WORD_W:0] v;
		logic signed [aocc_pkg::WORD_W:0] lo;
		logic signed [aocc_pkg::WORD_W:0] hi;
		logic signed [aocc_pkg::WORD_W:0] c;
		v = {w[aocc_pkg::WORD_W-1], w};
		if (r == aocc_pkg::AOCC_RNG_PM10) begin
			lo = aocc_pkg::BIP_LO;
			hi = aocc_pkg::BIP_HI;
		end else begin
			lo = aocc_pkg::UNI_LO;
			hi = aocc_pkg::UNI_HI;
		end
		if (v < lo) begin
			c = lo;
		end else if (v > hi) begin
			c = hi;
		end else begin
			c = v;
		end
		conv = aocc_pkg::DAC_W'(c - lo);
	endfunction : conv

	function automatic logic [aocc_pkg::DAC_W-1:0] clr_code(input aocc_pkg::aocc_policy_t p,
			input aocc_pkg::aocc_range_t r);
		unique case (p)
			aocc_pkg::AOCC_POL_CLR_MAX: clr_code = aocc_pkg::CODE_MAX;
			aocc_pkg::AOCC_POL_CLR_ZERO: clr_code = (r == aocc_pkg::AOCC_RNG_PM10) ?
				aocc_pkg::CODE_MID : aocc_pkg::CODE_MIN;
			default: clr_code = aocc_pkg::CODE_MIN;
		endcase
	endfunction : clr_code

	// ==========================================
	// input buffer
	aocc_word_if wr_if ();
	aocc_word_if rd_if ();

	assign wr_if.valid = in_valid;
	assign wr_if.data = {in_first, in_word};
	assign in_ready = wr_if.ready;

	aocc_word_buf u_buf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wr(wr_if.snk),
		.rd(rd_if.src)
	);

	// a full set waiting for the next refresh stalls the buffer, then the source
	assign rd_if.ready = (st_q.fsm == aocc_pkg::AOCC_ST_RUN) && !st_q.set_full;

	// ==========================================
	// next state
	logic comm_err;
	logic tick_hit;
	logic take;
	logic [2:0] dr_a;
	logic [2:0] dr_b;

	assign comm_err = bus_comm_err || link_comm_err;
	assign tick_hit = (st_q.tick == TICK_LAST);
	assign take = rd_if.valid && rd_if.ready;

	always_comb begin
		st_d = st_q;
		st_d.upd = 1'b0;
		dr_a = dec_range(st_q.sw[aocc_pkg::SW_RNG_A_LSB +: 3]);
		dr_b = dec_range(st_q.sw[aocc_pkg::SW_RNG_B_LSB +: 3]);

		// pin synchroniser; a change counts once stages two and three agree
		st_d.s1 = dip_sw;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.sw = st_q.s3;
		end

		unique case (st_q.fsm)
			aocc_pkg::AOCC_ST_SETTLE: begin
				// switches only change with power off, so one capture suffices
				if (st_q.settle == aocc_pkg::SETTLE_CYCLES) begin
					st_d.fsm = aocc_pkg::AOCC_ST_RUN;
					st_d.net = st_q.sw[aocc_pkg::SW_NET_EN];
					if (st_q.sw[aocc_pkg::SW_NET_EN]) begin
						for (int i = 0; i < aocc_pkg::N_CH; i++) begin
							st_d.rng[i] = aocc_pkg::RNG_RESET;
						end
						st_d.pol = aocc_pkg::POL_RESET;
						st_d.fault = 2'h0;
					end else begin
						// pin 7 carries nothing and is not decoded
						st_d.rng[0] = aocc_pkg::aocc_range_t'(dr_a[1:0]);
						st_d.rng[1] = aocc_pkg::aocc_range_t'(dr_a[1:0]);
						st_d.rng[2] = aocc_pkg::aocc_range_t'(dr_b[1:0]);
						st_d.rng[3] = aocc_pkg::aocc_range_t'(dr_b[1:0]);
						st_d.fault = {~dr_b[2], ~dr_a[2]};
						st_d.pol = dec_policy(st_q.sw[aocc_pkg::SW_POL_A], st_q.sw[aocc_pkg::SW_POL_B]);
					end
				end else begin
					st_d.settle = st_q.settle + 3'h1;
				end
			end
			aocc_pkg::AOCC_ST_RUN: begin
				if (net_cfg_wr && st_q.net) begin
					for (int i = 0; i < aocc_pkg::N_CH; i++) begin
						st_d.rng[i] = aocc_pkg::aocc_range_t'(net_range[2*i +: 2]);
					end
					st_d.pol = aocc_pkg::aocc_policy_t'(net_policy);
				end
			end
		endcase

		// word collection; in_first realigns the set to output 0
		if (take) begin
			if (rd_if.data[aocc_pkg::WORD_W]) begin
				st_d.stage[0] = rd_if.data[aocc_pkg::WORD_W-1:0];
				st_d.widx = 2'h1;
			end else begin
				st_d.stage[st_q.widx] = rd_if.data[aocc_pkg::WORD_W-1:0];
				st_d.widx = st_q.widx + 2'h1;
				st_d.set_full = (st_q.widx == 2'h3);
			end
		end
		if (comm_err) begin
			// a half set would mix old and new frames
			st_d.widx = 2'h0;
		end

		// refresh
		st_d.tick = tick_hit ? '0 : st_q.tick + 17'h00001;
		if (tick_hit && st_q.fsm == aocc_pkg::AOCC_ST_RUN) begin
			st_d.upd = 1'b1;
			// a set completed on this very edge survives for the next refresh
			st_d.set_full = !st_q.set_full && st_d.set_full;
			for (int i = 0; i < aocc_pkg::N_CH; i++) begin
				if (st_q.fault[i/2]) begin
					st_d.dac[i] = aocc_pkg::CODE_MIN;
				end else if (comm_err) begin
					if (st_q.pol != aocc_pkg::AOCC_POL_HOLD) begin
						st_d.dac[i] = clr_code(st_q.pol, st_q.rng[i]);
					end
				end else if (st_q.set_full) begin
					st_d.dac[i] = conv(st_q.stage[i], st_q.rng[i]);
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// outputs
	assign dac_code = st_q.dac;
	assign dac_update = st_q.upd;
	assign range_sel = st_q.rng;
	assign policy_sel = st_q.pol;
	assign cfg_fault = st_q.fault;
	assign net_mode = st_q.net;
endmodule : aocc_top

// file: testbench/aocc_top_checker.sv
module aocc_top_checker #(
	parameter int REFRESH_CYCLES = 64
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic net_cfg_wr,
	input wire logic [7:0] net_range,
	input wire logic [1:0] net_policy,
	input wire logic bus_comm_err,
	input wire logic link_comm_err,
	input wire logic [3:0][12:0] dac_code,
	input wire logic dac_update,
	input wire logic [7:0] range_sel,
	input wire logic [1:0] policy_sel,
	input wire logic [1:0] cfg_fault,
	input wire logic net_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// helpers: settle age and gap between refreshes
	logic [2:0] up_q;
	logic [31:0] gap_q;
	logic seen_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_q <= 3'h0;
			gap_q <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
			gap_q <= dac_update ? 32'h1 : gap_q + 32'h1;
			seen_q <= seen_q | dac_update;
		end
	end
	// ==========================================
	// assertions
	AST_UPD_GAP: assert property (dac_update && seen_q |-> gap_q == REFRESH_CYCLES)
		else $error("refresh spacing wrong");
	AST_CODE_HOLD: assert property (!dac_update |-> $stable(dac_code))
		else $error("code moved outside refresh");
	AST_CFG_KEEP: assert property (up_q == 3'h7 && !(net_mode && net_cfg_wr)
		|=> $stable(range_sel) && $stable(policy_sel))
		else $error("config changed without write");
	AST_NET_WR: assert property (up_q == 3'h7 && net_mode && net_cfg_wr
		|=> range_sel == $past(net_range) && policy_sel == $past(net_policy))
		else $error("network setting not taken");
	AST_NET_START: assert property ($rose(net_mode) |-> range_sel == 8'h00 && policy_sel == 2'h0)
		else $error("network mode default wrong");
	AST_ERR_MIN: assert property (dac_update && $past(bus_comm_err || link_comm_err) && policy_sel == 2'h0
		|-> dac_code == 52'h0)
		else $error("clear to minimum wrong");
	AST_ERR_MAX: assert property (dac_update && $past(bus_comm_err || link_comm_err) && policy_sel == 2'h1
		&& cfg_fault == 2'h0 |-> dac_code == {4{13'h19c8}})
		else $error("clear to maximum wrong");
	AST_ERR_HOLD: assert property (dac_update && $past(bus_comm_err || link_comm_err) && policy_sel == 2'h3
		|-> $stable(dac_code))
		else $error("hold policy changed code");
endmodule : aocc_top_checker

bind aocc_top aocc_top_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.core_clk, .rst_n, .net_cfg_wr,
	.net_range, .net_policy, .bus_comm_err, .link_comm_err, .dac_code, .dac_update, .range_sel,
	.policy_sel, .cfg_fault, .net_mode);

// file: testbench/aocc_master_model.sv
module aocc_master_model (
	input wire logic core_clk,
	input wire logic in_ready,
	output logic in_valid,
	output logic in_first,
	output logic [15:0] in_word
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		in_valid = 1'b0;
		in_first = 1'b0;
		in_word = 16'h0000;
	end
	// ws[15:0] is output 0; negative words already two's complement
	task automatic send_set(input logic [63:0] ws);
		@(posedge core_clk);
		for (int i = 0; i < 4; i++) begin
			in_valid <= 1'b1;
			in_first <= (i == 0);
			in_word <= ws[16*i +: 16];
			do @(negedge core_clk); while (in_ready !== 1'b1);
			@(posedge core_clk);
		end
		in_valid <= 1'b0;
		in_first <= 1'b0;
		// released word lines show garbage, not the last word
		in_word <= ~ws[63:48];
	endtask : send_set
endmodule : aocc_master_model

// file: testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst_n, net_cfg_wr, bus_comm_err, link_comm_err, in_valid, in_first, in_ready;
	logic dac_update, net_mode;
	logic [aocc_pkg::SW_W-1:0] dip_sw;
	logic [7:0] net_range, range_sel;
	logic [1:0] net_policy, policy_sel, cfg_fault;
	logic [15:0] in_word;
	logic [aocc_pkg::N_CH-1:0][aocc_pkg::DAC_W-1:0] dac_code;
	int n_errors = 0;
	int checks_done = 0;
	aocc_top #(.REFRESH_CYCLES(64)) dut (.core_clk, .rst_n, .dip_sw, .net_cfg_wr, .net_range, .net_policy,
		.bus_comm_err, .link_comm_err, .in_valid, .in_first, .in_word, .in_ready, .dac_code, .dac_update,
		.range_sel, .policy_sel, .cfg_fault, .net_mode);
	aocc_master_model u_master (.core_clk, .in_ready, .in_valid, .in_first, .in_word);
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ==========================================
	// tasks
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	// switches only count at reset, so each setup needs one
	task automatic do_reset(input logic [9:0] sw);
		@(posedge core_clk);
		rst_n <= 1'b0;
		dip_sw <= sw;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask : do_reset
	task automatic wait_upd();
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge core_clk);
			if (dac_update === 1'b1) break;
		end
		if (i == 200) check("dac_update", 64'(dac_update), 64'h1);
	endtask : wait_upd
	task automatic cfg(input logic [7:0] rng, input logic [1:0] pol, input logic [1:0] flt, input logic nm);
		check("range_sel", 64'(range_sel), 64'(rng));
		check("policy_sel", 64'(policy_sel), 64'(pol));
		check("cfg_fault", 64'(cfg_fault), 64'(flt));
		check("net_mode", 64'(net_mode), 64'(nm));
	endtask : cfg
	task automatic netwr(input logic [7:0] rng, input logic [1:0] pol);
		@(posedge core_clk);
		net_cfg_wr <= 1'b1;
		net_range <= rng;
		net_policy <= pol;
		@(posedge core_clk);
		net_cfg_wr <= 1'b0;
		@(negedge core_clk);
	endtask : netwr
	// start right after a refresh so the set lands before the next one
	task automatic load(input logic [63:0] ws, input logic [51:0] exp);
		wait_upd();
		u_master.send_set(ws);
		wait_upd();
		check("dac_code", 64'(dac_code), 64'(exp));
	endtask : load
	task automatic err_cycle(input logic b, input logic [51:0] exp);
		@(posedge core_clk);
		bus_comm_err <= b;
		link_comm_err <= !b;
		wait_upd();
		check("dac_code", 64'(dac_code), 64'(exp));
		@(posedge core_clk);
		bus_comm_err <= 1'b0;
		link_comm_err <= 1'b0;
	endtask : err_cycle
	// ==========================================
	// tests
	initial begin
		rst_n = 1'b0;
		dip_sw = 10'h000;
		net_cfg_wr = 1'b0;
		net_range = 8'h00;
		net_policy = 2'h0;
		bus_comm_err = 1'b0;
		link_comm_err = 1'b0;
		do_reset(10'h000);
		cfg(8'h00, 2'h0, 2'h0, 1'b0);
		check("in_ready", 64'(in_ready), 64'h1);
		load({16'h7fff, 16'h8000, 16'h1770, 16'h0000}, {13'h19c8, 13'h0000, 13'h189c, 13'h012c});
		// second set stalls in the buffer until the first is applied
		u_master.send_set({4{16'h0000}});
		fork
			u_master.send_set({16'h0064, 16'h00c8, 16'h012c, 16'h0190});
			begin
				repeat (6) @(negedge core_clk);
				check("in_ready", 64'(in_ready), 64'h0);
			end
		join
		check("dac_code", 64'(dac_code), 64'({4{13'h012c}}));
		wait_upd();
		check("dac_code", 64'(dac_code), 64'({13'h0190, 13'h01f4, 13'h0258, 13'h02bc}));
		@(posedge core_clk);
		dip_sw <= 10'h3bf;
		netwr(8'hff, 2'h3);
		repeat (8) @(negedge core_clk);
		cfg(8'h00, 2'h0, 2'h0, 1'b0);
		err_cycle(1'b1, 52'h0);
		do_reset(10'h0bb);
		check("range_sel", 64'(range_sel[3:0]), 64'hf);
		check("policy_sel", 64'(policy_sel), 64'h2);
		check("cfg_fault", 64'(cfg_fault), 64'h2);
		load({16'h1234, 16'h0000, 16'h0bb8, 16'hf448}, {13'h0, 13'h0, 13'h189c, 13'h012c});
		err_cycle(1'b0, {13'h0, 13'h0, 13'h0ce4, 13'h0ce4});
		do_reset(10'h300);
		cfg(8'h00, 2'h0, 2'h0, 1'b1);
		netwr(8'he4, 2'h1);
		cfg(8'he4, 2'h1, 2'h0, 1'b1);
		load({16'hf448, 16'h0000, 16'h0000, 16'h0000}, {4{13'h012c}});
		err_cycle(1'b1, {4{13'h19c8}});
		netwr(8'he4, 2'h2);
		err_cycle(1'b0, {13'h0ce4, 13'h0000, 13'h0000, 13'h0000});
		netwr(8'he4, 2'h3);
		load({16'h0bb8, 16'h1770, 16'h1770, 16'h1770}, {4{13'h189c}});
		err_cycle(1'b0, {4{13'h189c}});
		stop_test();
	end
	initial begin
		repeat (6000) @(posedge core_clk);
		n_errors++;
		stop_test();
	end
endmodule : tb
